// file: verilog/crxb_top.sv
// Function
// RULE_01: storing a message sets bit 7 full
// RULE_02: full buffer never takes a new message
// RULE_03: software clears full after reading, write-only
// RULE_04: buffer0 irq re-sets while full remains
// RULE_05: legacy mode 11 takes every message
// RULE_06: legacy mode 10 takes valid extended only
// RULE_07: legacy mode 01 takes valid standard only
// RULE_08: legacy mode 00 follows filter extended enable
// RULE_09: enhanced mode bit bypasses filters when set; code applies buffer0's bit only, buffer1's bit has no effect
// RULE_10: remote flag at bit 3 or 5
// RULE_11: enhanced filter hit code in bits 4:0
// RULE_12: legacy buffer0 bit 0 is filter hit
// RULE_13: double-buffer sends buffer0 overflow to buffer1
// RULE_14: bit 1 mirrors double-buffer enable read-only
// RULE_15: legacy buffer1 three-bit filter hit code
// RULE_16: legacy bit 4 reads zero; reset zero
// RULE_17: substitute remote bit equals rtr if standard
// RULE_18: operating mode picks legacy or enhanced layout
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "crxb_cfg.svh"

module crxb_top
   import crxb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] op_mode,
   input wire logic rx_valid,
   input wire crxb_frame_t rx_frame,
   output logic irq,
   output logic srr0,
   output logic srr1
);

   logic rst_s1;
   logic rst_s2;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= `CRXB_Z1;
         rst_s2 <= `CRXB_Z1;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   wire rst_i_n = rst_s2;

   crxb_buf_t b0;
   crxb_buf_t b1;
   logic [1:0] receive_mode_low;
   logic [1:0] receive_mode_high;
   logic dben;
   logic [`CRXB_NIRQ-1:0] stat;
   logic [`CRXB_NIRQ-1:0] mask;

   // layout and bus decode
   wire legacy = (op_mode == `CRXB_OP_LEGACY); // [RULE_18]
   wire req = avs_read | avs_write;
   wire take = req & ~avs_waitrequest;
   wire wr_ok = take & avs_write & avs_byteenable[0];
   wire rd_ok = take & avs_read;
   wire sel_c0 = (avs_address == `CRXB_A_CTL0);
   wire sel_c1 = (avs_address == `CRXB_A_CTL1);
   wire sel_st = (avs_address == `CRXB_A_STAT);
   wire sel_mk = (avs_address == `CRXB_A_MASK);
   wire sel_sr = (avs_address == `CRXB_A_SRR);
   wire [7:0] wd = avs_writedata[7:0];

   // acceptance per buffer mode
   function automatic logic accepts(
      input logic lg,
      input logic [1:0] m,
      input crxb_frame_t f
   );
      logic ok;
      ok = ~f.err & f.match;
      if (lg) begin
         if (m == `CRXB_M_ALL)
            accepts = 1'b1; // [RULE_05]
         else if (m == `CRXB_M_EXT)
            accepts = ok & f.ext & f.fext; // [RULE_06]
         else if (m == `CRXB_M_STD)
            accepts = ok & ~f.ext & ~f.fext; // [RULE_07]
         else
            accepts = ok & (f.ext == f.fext); // [RULE_08]
      end else begin
         accepts = m[1] | ok; // [RULE_09]
      end
   endfunction : accepts

   // legacy: filters 0..1 feed buffer0, 2..5 feed buffer1
   wire to_b1_first = legacy &
      (rx_frame.fhit >= `CRXB_BUF1_MIN);
   wire acc0 = accepts(legacy, receive_mode_low, rx_frame);
   wire acc1 = accepts(legacy, receive_mode_high, rx_frame);
   // enhanced spills to buffer1 too; only legacy gates it
   wire spill = ~legacy | dben;
   wire try0 = rx_valid & ~to_b1_first & acc0;
   wire st0 = try0 & ~b0.full; // [RULE_02]
   wire st1_dir = rx_valid & to_b1_first & acc1;
   wire st1_ovf = try0 & b0.full & spill; // [RULE_13]
   wire try1 = st1_dir | st1_ovf;
   wire st1 = try1 & ~b1.full; // [RULE_02]
   wire drop = (try0 & b0.full & ~spill) |
      (try1 & b1.full);

   // software clears full by writing zero only
   wire clr0 = wr_ok & sel_c0 & ~wd[`CRXB_B_FULL]; // [RULE_03]
   wire clr1 = wr_ok & sel_c1 & ~wd[`CRXB_B_FULL]; // [RULE_03]

   crxb_buf_t next_b0;
   crxb_buf_t next_b1;
   wire crxb_buf_t cap = '{full: 1'b1,
      rtr: rx_frame.rtr, ext: rx_frame.ext,
      fhit: rx_frame.fhit};

   // contents stay after a clear; only the flag drops
   wire crxb_buf_t hold0 = '{full: b0.full & ~clr0,
      rtr: b0.rtr, ext: b0.ext, fhit: b0.fhit};
   wire crxb_buf_t hold1 = '{full: b1.full & ~clr1,
      rtr: b1.rtr, ext: b1.ext, fhit: b1.fhit};
   assign next_b0 = st0 ? cap : hold0; // [RULE_01]
   assign next_b1 = st1 ? cap : hold1; // [RULE_01]

   always_ff @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         b0 <= '0;
         b1 <= '0;
      end else begin
         b0 <= next_b0;
         b1 <= next_b1;
      end
   end

   // mode bits; enhanced layout writes only bit 6
   wire [1:0] next_receive_mode_low = !(wr_ok & sel_c0) ? receive_mode_low :
      legacy ? wd[`CRXB_B_RECEIVE_MODE_HIGH:`CRXB_B_RECEIVE_MODE_LOW] :
      {wd[`CRXB_B_RECEIVE_MODE_HIGH], receive_mode_low[0]};
   wire [1:0] next_receive_mode_high = !(wr_ok & sel_c1) ? receive_mode_high :
      legacy ? wd[`CRXB_B_RECEIVE_MODE_HIGH:`CRXB_B_RECEIVE_MODE_LOW] :
      {wd[`CRXB_B_RECEIVE_MODE_HIGH], receive_mode_high[0]};
   wire next_dben = (wr_ok & sel_c0 & legacy) ?
      wd[`CRXB_B_DBEN] : dben;

   always_ff @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         receive_mode_low <= `CRXB_Z2; // [RULE_16]
         receive_mode_high <= `CRXB_Z2;
         dben <= `CRXB_Z1;
      end else begin
         receive_mode_low <= next_receive_mode_low;
         receive_mode_high <= next_receive_mode_high;
         dben <= next_dben;
      end
   end

   // interrupt status: set wins over read-clear
   wire stat_rd = rd_ok & sel_st;
   logic [`CRXB_NIRQ-1:0] ev;
   assign ev[`CRXB_I_B0] = st0 | b0.full; // [RULE_04]
   assign ev[`CRXB_I_B1] = st1;
   assign ev[`CRXB_I_OVF] = drop;
   wire [`CRXB_NIRQ-1:0] next_stat =
      ev | (stat & {`CRXB_NIRQ{~stat_rd}});
   wire [`CRXB_NIRQ-1:0] next_mask =
      (wr_ok & sel_mk) ? wd[`CRXB_NIRQ-1:0] : mask;
   wire next_irq = |(next_stat & next_mask);

   always_ff @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         stat <= `CRXB_Z3;
         mask <= `CRXB_Z3;
         irq <= `CRXB_Z1;
      end else begin
         stat <= next_stat;
         mask <= next_mask;
         irq <= next_irq;
      end
   end

   // substitute remote bits follow buffer contents
   wire next_srr0 = next_b0.rtr & ~next_b0.ext; // [RULE_17]
   wire next_srr1 = next_b1.rtr & ~next_b1.ext; // [RULE_17]

   always_ff @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         srr0 <= `CRXB_Z1;
         srr1 <= `CRXB_Z1;
      end else begin
         srr0 <= next_srr0;
         srr1 <= next_srr1;
      end
   end

   // register images
   logic [7:0] c0_img;
   logic [7:0] c1_img;
   always_comb begin
      c0_img = `CRXB_Z8;
      c1_img = `CRXB_Z8;
      c0_img[`CRXB_B_FULL] = b0.full;
      c1_img[`CRXB_B_FULL] = b1.full;
      c0_img[`CRXB_B_RECEIVE_MODE_HIGH] = receive_mode_low[1];
      c1_img[`CRXB_B_RECEIVE_MODE_HIGH] = receive_mode_high[1];
      if (legacy) begin
         // bit 4 left zero [RULE_16]
         c0_img[`CRXB_B_RECEIVE_MODE_LOW] = receive_mode_low[0];
         c0_img[`CRXB_B_RTRL] = b0.rtr; // [RULE_10]
         c0_img[`CRXB_B_DBEN] = dben;
         c0_img[`CRXB_B_JOFF] = dben; // [RULE_14]
         c0_img[`CRXB_B_FH0] = b0.fhit[0]; // [RULE_12]
         c1_img[`CRXB_B_RECEIVE_MODE_LOW] = receive_mode_high[0];
         c1_img[`CRXB_B_RTRL] = b1.rtr; // [RULE_10]
         c1_img[2:0] = b1.fhit[2:0]; // [RULE_15]
      end else begin
         c0_img[`CRXB_B_RTRE] = b0.rtr; // [RULE_10]
         c0_img[4:0] = b0.fhit; // [RULE_11]
         c1_img[`CRXB_B_RTRE] = b1.rtr; // [RULE_10]
         c1_img[4:0] = b1.fhit; // [RULE_11]
      end
   end

   wire [31:0] rd_mux =
      sel_c0 ? {24'h000000, c0_img} :
      sel_c1 ? {24'h000000, c1_img} :
      sel_st ? {29'h0000000, stat} :
      sel_mk ? {29'h0000000, mask} :
      sel_sr ? {30'h0000000, srr1, srr0} :
      `CRXB_Z32;

   // one wait state on every access
   wire next_wait = ~(req & avs_waitrequest);
   wire [31:0] next_rdata = (req & avs_waitrequest
      & avs_read) ? rd_mux : avs_readdata;

   always_ff @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= `CRXB_Z32;
      end else begin
         avs_waitrequest <= next_wait;
         avs_readdata <= next_rdata;
      end
   end

   // checks
   sequence s_store0;
      st0;
   endsequence

   sequence s_full0_held;
      b0.full & ~clr0;
   endsequence

   property p_full_set;
      @(posedge clk) disable iff (!rst_i_n)
      s_store0 |=> b0.full;
   endproperty
   a_full_set: assert property (p_full_set) // [RULE_01]
      else $error("full flag not set on store");

   property p_no_load_full;
      @(posedge clk) disable iff (!rst_i_n)
      s_full0_held |=> $stable(b0.fhit) && b0.full;
   endproperty
   a_no_load_full: assert property (p_no_load_full) // [RULE_02]
      else $error("full buffer was overwritten");

   property p_full_no_self_set;
      @(posedge clk) disable iff (!rst_i_n)
      $rose(b1.full) |-> $past(st1);
   endproperty
   a_full_no_self_set: assert property (p_full_no_self_set) // [RULE_03]
      else $error("full flag set without a store");

   property p_irq_reset;
      @(posedge clk) disable iff (!rst_i_n)
      b0.full ##1 b0.full |-> stat[`CRXB_I_B0];
   endproperty
   a_irq_reset: assert property (p_irq_reset) // [RULE_04]
      else $error("buffer0 irq not re-set while full");

   property p_mode_all;
      @(posedge clk) disable iff (!rst_i_n)
      legacy && receive_mode_low == `CRXB_M_ALL && rx_valid
      && !to_b1_first && !b0.full |=> b0.full;
   endproperty
   a_mode_all: assert property (p_mode_all) // [RULE_05]
      else $error("mode all dropped a message");

   property p_mode_ext;
      @(posedge clk) disable iff (!rst_i_n)
      legacy && receive_mode_low == `CRXB_M_EXT && st0 |-> rx_frame.ext;
   endproperty
   a_mode_ext: assert property (p_mode_ext) // [RULE_06]
      else $error("mode ext stored a standard frame");

   property p_mode_std;
      @(posedge clk) disable iff (!rst_i_n)
      legacy && receive_mode_low == `CRXB_M_STD && st0
      |-> !rx_frame.ext && !rx_frame.err;
   endproperty
   a_mode_std: assert property (p_mode_std) // [RULE_07]
      else $error("mode std stored a bad frame");

   property p_enh_filter;
      @(posedge clk) disable iff (!rst_i_n)
      !legacy && !receive_mode_low[1] && st0
      |-> rx_frame.match && !rx_frame.err;
   endproperty
   a_enh_filter: assert property (p_enh_filter) // [RULE_09]
      else $error("enhanced mode bypassed filters");

   property p_double_buf;
      @(posedge clk) disable iff (!rst_i_n)
      legacy && dben && try0 && b0.full && !b1.full
      |=> b1.full && b1.fhit == $past(rx_frame.fhit);
   endproperty
   a_double_buf: assert property (p_double_buf) // [RULE_13]
      else $error("overflow not written to buffer1");

   property p_srr;
      @(posedge clk) disable iff (!rst_i_n)
      srr0 == (b0.rtr & ~b0.ext)
      && srr1 == (b1.rtr & ~b1.ext);
   endproperty
   a_srr: assert property (p_srr) // [RULE_17]
      else $error("substitute remote bit wrong");

   property p_gap_zero;
      @(posedge clk) disable iff (!rst_i_n)
      rd_ok && $past(legacy) && (sel_c0 || sel_c1)
      |-> !avs_readdata[`CRXB_B_GAP];
   endproperty
   a_gap_zero: assert property (p_gap_zero) // [RULE_16]
      else $error("legacy bit 4 read as one");

   property p_jump_mirror;
      @(posedge clk) disable iff (!rst_i_n)
      rd_ok && $past(legacy) && sel_c0
      |-> avs_readdata[`CRXB_B_JOFF] == avs_readdata[`CRXB_B_DBEN];
   endproperty
   a_jump_mirror: assert property (p_jump_mirror) // [RULE_14]
      else $error("jump offset mirror differs");

   property p_enh_fhit;
      @(posedge clk) disable iff (!rst_i_n)
      !legacy && st0 |=> b0.fhit == $past(rx_frame.fhit);
   endproperty
   a_enh_fhit: assert property (p_enh_fhit) // [RULE_11]
      else $error("filter hit code not captured");

   property p_drop_flag;
      @(posedge clk) disable iff (!rst_i_n)
      drop |=> stat[`CRXB_I_OVF];
   endproperty
   a_drop_flag: assert property (p_drop_flag) // [RULE_02]
      else $error("refused message not flagged");

   property p_dben_kept;
      @(posedge clk) disable iff (!rst_i_n)
      !legacy && wr_ok && sel_c0 |=> $stable(dben);
   endproperty
   a_dben_kept: assert property (p_dben_kept) // [RULE_18]
      else $error("double-buffer enable written in enhanced");

   property p_bus_answer;
      @(posedge clk) disable iff (!rst_i_n)
      req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer timing wrong");

endmodule : crxb_top

// file: verilog/crxb_cfg.svh
`ifndef CRXB_CFG_SVH
`define CRXB_CFG_SVH
`define CRXB_A_CTL0 4'h0
`define CRXB_A_CTL1 4'h1
`define CRXB_A_STAT 4'h2
`define CRXB_A_MASK 4'h3
`define CRXB_A_SRR 4'h4
`define CRXB_B_FULL 7
`define CRXB_B_RECEIVE_MODE_HIGH 6
`define CRXB_B_RECEIVE_MODE_LOW 5
`define CRXB_B_RTRE 5
`define CRXB_B_RTRL 3
`define CRXB_B_DBEN 2
`define CRXB_B_JOFF 1
`define CRXB_B_FH0 0
`define CRXB_B_GAP 4
`define CRXB_M_ALL 2'h3
`define CRXB_M_EXT 2'h2
`define CRXB_M_STD 2'h1
`define CRXB_M_VAL 2'h0
`define CRXB_OP_LEGACY 2'h0
`define CRXB_I_B0 0
`define CRXB_I_B1 1
`define CRXB_I_OVF 2
`define CRXB_NIRQ 3
`define CRXB_BUF1_MIN 5'h02
`define CRXB_Z1 1'h0
`define CRXB_Z2 2'h0
`define CRXB_Z3 3'h0
`define CRXB_Z8 8'h00
`define CRXB_Z32 32'h0000_0000
`endif

// file: verilog/crxb_pkg.sv
package crxb_pkg;
   // one received frame from the protocol engine
   typedef struct packed {
      logic ext;
      logic rtr;
      logic err;
      logic match;
      logic fext;
      logic [4:0] fhit;
   } crxb_frame_t;

   // captured state of one receive buffer
   typedef struct packed {
      logic full;
      logic rtr;
      logic ext;
      logic [4:0] fhit;
   } crxb_buf_t;
endpackage : crxb_pkg

// file: verif/crxb_engine_model.sv
`timescale 1ns/1ps
// behavioural protocol engine: offers one finished frame per send pulse
module crxb_engine_model
   import crxb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic send,
   input wire crxb_frame_t frame_in,
   output logic rx_valid,
   output crxb_frame_t rx_frame
);
   // idle frame lines toggle so a stale frame is never mistaken for data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_frame <= '0;
      end else begin
         rx_valid <= send;
         rx_frame <= send ? frame_in : ~rx_frame;
      end
   end
endmodule : crxb_engine_model

// file: verif/can_rx_buffer_control_bench.sv
`timescale 1ns/1ps
`include "crxb_cfg.svh"
module can_rx_buffer_control_bench;
   import crxb_pkg::*;
   logic clk;
   logic rst_n = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] be = 4'hF;
   logic [1:0] op_mode = 2'h0;
   logic send = 1'b0;
   crxb_frame_t frm = '0;
   logic [31:0] rdat;
   logic wait_req;
   logic rx_valid;
   crxb_frame_t rx_frame;
   logic irq;
   logic srr0;
   logic srr1;
   logic [31:0] d;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;

   crxb_top DUT(.clk(clk), .rst_n(rst_n), .avs_address(adr),
      .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_req), .op_mode(op_mode),
      .rx_valid(rx_valid), .rx_frame(rx_frame), .irq(irq),
      .srr0(srr0), .srr1(srr1));

   crxb_engine_model partner(.clk(clk), .rst_n(rst_n), .send(send),
      .frame_in(frm), .rx_valid(rx_valid), .rx_frame(rx_frame));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc >= 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== {24'h00_0000, e}) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // holds the request until waitrequest is sampled low
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [7:0] v);
      @(posedge clk);
      adr <= a;
      rd_en <= !w;
      wr_en <= w;
      wdat <= {24'h00_0000, v};
      do @(posedge clk); while (wait_req !== 1'b0);
      d = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask : acc

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      acc(1'b1, a, v);
   endtask : wr

   task automatic rc(input string nm, input logic [3:0] a,
                     input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(nm, e, d);
   endtask : rc

   // frame bits {ext,rtr,err,match,fext} then filter hit
   task automatic tx(input logic [4:0] b, input logic [4:0] h);
      @(posedge clk);
      send <= 1'b1;
      frm <= {b, h};
      @(posedge clk);
      send <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : tx

   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         rc("reset reg", i[3:0], 8'h00);
      end
      chk("irq", 8'h00, {31'h0000_0000, irq});
   endtask : t_reset

   task automatic t_irq;
      wr(`CRXB_A_MASK, 8'h01);
      tx(5'h02, 5'h00);
      chk("irq", 8'h01, {31'h0000_0000, irq});
      rc("status", `CRXB_A_STAT, 8'h01);
      rc("status again", `CRXB_A_STAT, 8'h01);
      chk("irq held", 8'h01, {31'h0000_0000, irq});
      wr(`CRXB_A_CTL0, 8'h00);
      rc("status after clear", `CRXB_A_STAT, 8'h01);
      rc("status drained", `CRXB_A_STAT, 8'h00);
      chk("irq low", 8'h00, {31'h0000_0000, irq});
      wr(`CRXB_A_MASK, 8'h00);
      tx(5'h02, 5'h00);
      chk("irq masked", 8'h00, {31'h0000_0000, irq});
      wr(`CRXB_A_CTL0, 8'h00);
   endtask : t_irq

   // std valid, ext valid, errored; ok holds the expected full bits
   task automatic mode_run(input logic [1:0] m, input logic [2:0] ok);
      logic [4:0] fb[3] = '{5'h02, 5'h13, 5'h04};
      for (int k = 0; k < 3; k++) begin
         wr(`CRXB_A_CTL0, {1'h0, m, 5'h00});
         tx(fb[k], 5'h00);
         acc(1'b0, `CRXB_A_CTL0, 8'h00);
         chk("mode full", {7'h00, ok[k]}, {31'h0, d[7]});
      end
   endtask : mode_run

   task automatic t_modes;
      mode_run(2'h0, 3'h3);
      mode_run(2'h1, 3'h1);
      mode_run(2'h2, 3'h2);
      mode_run(2'h3, 3'h7);
      wr(`CRXB_A_CTL0, 8'h00);
   endtask : t_modes

   task automatic t_dbuf;
      wr(`CRXB_A_CTL0, 8'h04);
      rc("dben mirror", `CRXB_A_CTL0, 8'h06);
      tx(5'h0A, 5'h01);
      rc("ctl0", `CRXB_A_CTL0, 8'h8F);
      chk("srr0", 8'h01, {31'h0000_0000, srr0});
      tx(5'h1B, 5'h00);
      rc("ctl0 kept", `CRXB_A_CTL0, 8'h8F);
      rc("ctl1", `CRXB_A_CTL1, 8'h88);
      chk("srr1", 8'h00, {31'h0000_0000, srr1});
      acc(1'b0, `CRXB_A_STAT, 8'h00);
      tx(5'h02, 5'h03);
      rc("drop status", `CRXB_A_STAT, 8'h05);
      wr(`CRXB_A_CTL1, 8'h00);
      wr(`CRXB_A_CTL0, 8'h00);
      tx(5'h02, 5'h05);
      rc("ctl1 filter5", `CRXB_A_CTL1, 8'h85);
      be <= 4'h0;
      wr(`CRXB_A_CTL1, 8'h00);
      be <= 4'hF;
      rc("ctl1 no lane", `CRXB_A_CTL1, 8'h85);
      wr(`CRXB_A_CTL1, 8'h00);
   endtask : t_dbuf

   task automatic t_enh;
      op_mode <= 2'h1;
      tx(5'h0A, 5'h0F);
      rc("enh ctl0", `CRXB_A_CTL0, 8'hAF);
      chk("enh srr0", 8'h01, {31'h0000_0000, srr0});
      wr(`CRXB_A_CTL0, 8'hFF);
      rc("enh ctl0 ro", `CRXB_A_CTL0, 8'hEF);
      tx(5'h12, 5'h09);
      rc("enh ctl1", `CRXB_A_CTL1, 8'h89);
      wr(`CRXB_A_CTL0, 8'h40);
      tx(5'h14, 5'h03);
      rc("enh take all", `CRXB_A_CTL0, 8'hC3);
      wr(`CRXB_A_CTL0, 8'h00);
      wr(`CRXB_A_CTL1, 8'h00);
      tx(5'h14, 5'h03);
      acc(1'b0, `CRXB_A_CTL0, 8'h00);
      chk("enh filtered", 8'h00, {31'h0, d[7]});
      wr(`CRXB_A_CTL0, 8'h80);
      rc("full not settable", `CRXB_A_CTL0, 8'h03);
   endtask : t_enh

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_irq();
      t_modes();
      t_dbuf();
      t_enh();
      wrap_up();
   end
endmodule : can_rx_buffer_control_bench
